// *** verilog/ccc_pkg.sv ***
// Purpose: shared constants for the cap-divider channel and capacitor control block
// Assumes: 8-bit register port, bank-relative offsets decoded with a bank number
// Notes:   bank 14 offsets, converter two offsets and the cvd-only registers are local choices
package ccc_pkg;
  localparam logic [3:0] BANK_STD       = 4'h1;
  localparam logic [3:0] BANK_CVD1      = 4'hE;
  localparam logic [3:0] BANK_CVD2      = 4'hF;
  // standard register offsets in bank one
  localparam logic [7:0] OFS_RES_LO     = 8'h9B;
  localparam logic [7:0] OFS_RES_HI     = 8'h9C;
  localparam logic [7:0] OFS_CTL0       = 8'h9D;
  localparam logic [7:0] OFS_CTL1       = 8'h9E;
  localparam logic [7:0] OFS_CTL2       = 8'h9F;
  // converter one storage seen from bank fourteen, converter two storage from bank fifteen
  localparam logic [7:0] OFS_X_CTL0     = 8'h10;
  localparam logic [7:0] OFS_X_CTL1     = 8'h11;
  localparam logic [7:0] OFS_X_CTL2     = 8'h12;
  localparam logic [7:0] OFS_X_RES0_LO  = 8'h13;
  localparam logic [7:0] OFS_X_RES0_HI  = 8'h14;
  localparam logic [7:0] OFS_X_RES1_LO  = 8'h15;
  localparam logic [7:0] OFS_X_RES1_HI  = 8'h16;
  localparam logic [7:0] OFS_X_SEC      = 8'h17;
  localparam logic [7:0] OFS_X_CAP      = 8'h18;
  localparam logic [7:0] OFS_X_STAT     = 8'h19;
  // control zero and control two field layout, write masks and reset value
  localparam int         CTL0_ON        = 0;
  localparam int         CTL0_GO        = 1;
  localparam int         CTL0_CH_LSB    = 2;
  localparam logic [7:0] CTL0_MASK      = 8'h7F;
  localparam int         CTL2_TRIG_EN   = 0;
  localparam int         CTL2_DOUBLE    = 1;
  localparam int         CTL2_PRE_POL   = 2;
  localparam logic [7:0] SEC_MASK       = 8'h7F;
  localparam logic [7:0] CAP_MASK       = 8'h0F;
  localparam logic [7:0] REG_RESET      = 8'h00;
  // sequence timing in clock cycles
  localparam int         PRE_CYCLES     = 8;
  localparam int         ACQ_CYCLES     = 8;
  localparam int         CONV_CYCLES    = 12;
  localparam int         GAP_CYCLES     = 2;
  localparam int         CNT_W          = 4;
  localparam int         NCH            = 7;
  typedef enum logic [2:0] {
    CCC_IDLE, CCC_PRE, CCC_ACQ, CCC_CONV, CCC_GAP
  } ccc_state_t;
endpackage

// *** verilog/ccc_reg8.sv ***
// Purpose: one byte register with write mask and reset value
// Assumes: synchronous active-low reset
// Notes:   shared by every plain software register of the block
`timescale 1ns/1ps
`default_nettype none
module ccc_reg8 import ccc_pkg::*; (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       we,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] mask,
  output logic      [7:0] q
);
  always_ff @(posedge mclk) begin
    if (!rst_n) q <= REG_RESET;
    else if (we) q <= wdata & mask;
  end
endmodule
`default_nettype wire

// *** verilog/ccc_seq.sv ***
// Purpose: pre-charge, acquisition and conversion sequencer for one converter
// Assumes: converter result arrives as a 10-bit word at end of conversion
// Notes:   double sample inserts a two-cycle gap before the second pass
`timescale 1ns/1ps
`default_nettype none
module ccc_seq import ccc_pkg::*; (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  input  wire logic       start,
  input  wire logic       abort,
  input  wire logic       double_en,
  output logic            precharge,
  output logic            acquire,
  output logic            converting,
  output logic            second,
  output logic            done,
  output logic            store0,
  output logic            store1,
  output logic            halted
);
  ccc_state_t             st_q;
  logic [CNT_W-1:0]       cnt_q;
  logic                   sec_q;
  wire                    last = (cnt_q == '0);
  wire                    finish = (st_q == CCC_CONV) && last;

  assign precharge  = (st_q == CCC_PRE);
  assign acquire    = (st_q == CCC_ACQ);
  assign converting = (st_q == CCC_CONV);
  assign second     = sec_q;
  assign store0     = finish && !sec_q;
  assign store1     = finish && sec_q;
  assign done       = finish && (sec_q || !double_en);
  assign halted     = (abort || !enable) && (st_q != CCC_IDLE);

  always_ff @(posedge mclk) begin
    if (!rst_n || halted) begin
      st_q  <= CCC_IDLE;
      cnt_q <= '0;
      sec_q <= 1'b0;
    end else begin
      if (!last) cnt_q <= cnt_q - 1'b1;
      case (st_q)
        CCC_IDLE: if (start && enable) begin
          st_q  <= CCC_PRE;
          cnt_q <= CNT_W'(PRE_CYCLES - 1);
          sec_q <= 1'b0;
        end
        CCC_PRE: if (last) begin
          st_q  <= CCC_ACQ;
          cnt_q <= CNT_W'(ACQ_CYCLES - 1);
        end
        CCC_ACQ: if (last) begin
          st_q  <= CCC_CONV;
          cnt_q <= CNT_W'(CONV_CYCLES - 1);
        end
        CCC_CONV: if (last) begin
          if (double_en && !sec_q) begin
            st_q  <= CCC_GAP;
            cnt_q <= CNT_W'(GAP_CYCLES - 1);
            sec_q <= 1'b1;
          end else begin
            st_q <= CCC_IDLE;
          end
        end
        CCC_GAP: if (last) begin
          st_q  <= CCC_PRE;
          cnt_q <= CNT_W'(PRE_CYCLES - 1);
        end
        default: st_q <= CCC_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** verilog/ccc_top.sv ***
// Purpose: channel connection, extra capacitor and conversion control of two cap-divider converters
// Assumes: 8-bit register port with bank number; converter results fed in from the analog side
// Notes:   shared go bit lives in control one bit 1; status register mirrors sequence state
// Contract
// - extra capacitance sized by four-bit select field
// - extra capacitance disconnected during conversion
// - independent capacitor array per converter
// - five-bit primary channel select per converter
// - secondary channels enabled bit by bit
// - enabled secondary pins forced to input
// - analog select stays under software control
// - secondaries mimic primary drive during pre-charge
// - channels connect immediately on selection
// - go, shared go or trigger start sequence
// - double conversion fills result sets zero, one
// - converter one registers shared by banks one, fourteen
// - standard registers at offsets 9B through 9F
// - converter two has bank fifteen only
// - advanced names alias same converter two addresses
// - completion clears go, sets flag, stores result
`timescale 1ns/1ps
`default_nettype none
module ccc_top import ccc_pkg::*; (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  reg_bank,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic [1:0]  special_trigger,
  input  wire logic [9:0]  conv1_result,
  input  wire logic [9:0]  conv2_result,
  input  wire logic        flag_clear1,
  input  wire logic        flag_clear2,
  output logic      [1:0]  conv_done_flag,
  output logic      [4:0]  primary_channel_select1,
  output logic      [4:0]  primary_channel_select2,
  output logic      [1:0]  primary_connect,
  output logic      [NCH-1:0] secondary_connect1,
  output logic      [NCH-1:0] secondary_connect2,
  output logic      [NCH-1:0] secondary_force_input1,
  output logic      [NCH-1:0] secondary_force_input2,
  output logic      [NCH-1:0] secondary_drive_en1,
  output logic      [NCH-1:0] secondary_drive_en2,
  output logic      [1:0]  precharge_level,
  output logic      [3:0]  extra_cap_select1,
  output logic      [3:0]  extra_cap_select2
);
  // per-converter storage, index 0 is converter one
  logic [7:0] ctl0_q [2];
  logic [7:0] ctl1_q [2];
  logic [7:0] ctl2_q [2];
  logic [7:0] sec_q  [2];
  logic [7:0] cap_q  [2];
  logic [9:0] res0_q [2];
  logic [9:0] res1_q [2];
  logic [1:0] flag_q;
  logic [1:0] go_q;

  wire [1:0] pre, acq, conv, done, st0, st1, halt, scnd;

  // converter one answers in bank one and bank fourteen, converter two in fifteen only
  wire std1   = (reg_bank == BANK_STD);
  wire cvd1   = (reg_bank == BANK_CVD1);
  wire cvd2   = (reg_bank == BANK_CVD2);
  wire [1:0] hit_ctl0 = {cvd2 && reg_addr == OFS_X_CTL0,
                         (std1 && reg_addr == OFS_CTL0) || (cvd1 && reg_addr == OFS_X_CTL0)};
  wire [1:0] hit_ctl1 = {cvd2 && reg_addr == OFS_X_CTL1,
                         (std1 && reg_addr == OFS_CTL1) || (cvd1 && reg_addr == OFS_X_CTL1)};
  wire [1:0] hit_ctl2 = {cvd2 && reg_addr == OFS_X_CTL2,
                         (std1 && reg_addr == OFS_CTL2) || (cvd1 && reg_addr == OFS_X_CTL2)};
  wire [1:0] hit_sec  = {cvd2 && reg_addr == OFS_X_SEC, cvd1 && reg_addr == OFS_X_SEC};
  wire [1:0] hit_cap  = {cvd2 && reg_addr == OFS_X_CAP, cvd1 && reg_addr == OFS_X_CAP};

  // shared go lives in converter one control one; it starts both converters
  wire shared_go = reg_wr && hit_ctl1[0] && reg_wdata[CTL0_GO];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_conv
      wire on   = ctl0_q[g][CTL0_ON];
      wire wgo  = reg_wr && hit_ctl0[g];
      // a go written together with a cleared on bit is dropped, so it never starts a pass
      wire set_go = (wgo && reg_wdata[CTL0_GO] && reg_wdata[CTL0_ON]) || shared_go
                  || (ctl2_q[g][CTL2_TRIG_EN] && special_trigger[g]);
      // software clearing go while busy, before the cycle that asserts done, halts the pass without raising the flag
      wire abort_go = wgo && !reg_wdata[CTL0_GO] && go_q[g];

      ccc_reg8 u_ctl0 (.mclk(mclk), .rst_n(rst_n), .we(wgo), .wdata(reg_wdata),
                       .mask(CTL0_MASK & ~(8'h01 << CTL0_GO)), .q(ctl0_q[g]));
      ccc_reg8 u_ctl1 (.mclk(mclk), .rst_n(rst_n), .we(reg_wr && hit_ctl1[g]), .wdata(reg_wdata),
                       .mask(~(8'h01 << CTL0_GO)), .q(ctl1_q[g]));
      ccc_reg8 u_ctl2 (.mclk(mclk), .rst_n(rst_n), .we(reg_wr && hit_ctl2[g]), .wdata(reg_wdata),
                       .mask(8'hFF), .q(ctl2_q[g]));
      ccc_reg8 u_sec  (.mclk(mclk), .rst_n(rst_n), .we(reg_wr && hit_sec[g]), .wdata(reg_wdata),
                       .mask(SEC_MASK), .q(sec_q[g]));
      ccc_reg8 u_cap  (.mclk(mclk), .rst_n(rst_n), .we(reg_wr && hit_cap[g]), .wdata(reg_wdata),
                       .mask(CAP_MASK), .q(cap_q[g]));

      ccc_seq u_seq (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .enable     (on),
        .start      (set_go && !go_q[g]),
        .abort      (abort_go),
        .double_en  (ctl2_q[g][CTL2_DOUBLE]),
        .precharge  (pre[g]),
        .acquire    (acq[g]),
        .converting (conv[g]),
        .second     (scnd[g]),
        .done       (done[g]),
        .store0     (st0[g]),
        .store1     (st1[g]),
        .halted     (halt[g])
      );

      wire [9:0] res_in = (g == 0) ? conv1_result : conv2_result;

      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          go_q[g]   <= 1'b0;
          flag_q[g] <= 1'b0;
          res0_q[g] <= '0;
          res1_q[g] <= '0;
        end else begin
          // go stays high across both passes of a double sample
          if (done[g] || halt[g] || !on) go_q[g] <= 1'b0;
          else if (set_go) go_q[g] <= 1'b1;
          // hardware set beats a clear in the same cycle
          if (done[g]) flag_q[g] <= 1'b1;
          else if ((g == 0) ? flag_clear1 : flag_clear2) flag_q[g] <= 1'b0;
          // an aborted pass still transfers the partial word
          if (st0[g] || (halt[g] && !scnd[g])) res0_q[g] <= res_in;
          if (st1[g] || (halt[g] && scnd[g]))  res1_q[g] <= res_in;
        end
      end
    end
  endgenerate

  // read multiplexer; converter one standard result is result set zero
  logic [7:0] rd_d;
  wire [1:0] hit_r0l = {cvd2 && reg_addr == OFS_X_RES0_LO,
                        (std1 && reg_addr == OFS_RES_LO) || (cvd1 && reg_addr == OFS_X_RES0_LO)};
  wire [1:0] hit_r0h = {cvd2 && reg_addr == OFS_X_RES0_HI,
                        (std1 && reg_addr == OFS_RES_HI) || (cvd1 && reg_addr == OFS_X_RES0_HI)};
  wire [1:0] hit_r1l = {cvd2 && reg_addr == OFS_X_RES1_LO, cvd1 && reg_addr == OFS_X_RES1_LO};
  wire [1:0] hit_r1h = {cvd2 && reg_addr == OFS_X_RES1_HI, cvd1 && reg_addr == OFS_X_RES1_HI};
  wire [1:0] hit_st  = {cvd2 && reg_addr == OFS_X_STAT, cvd1 && reg_addr == OFS_X_STAT};

  always_comb begin
    rd_d = 8'h00;
    for (int i = 0; i < 2; i++) begin
      if (hit_ctl0[i]) rd_d = ctl0_q[i] | {6'h00, go_q[i], 1'b0};
      if (hit_ctl1[i]) rd_d = ctl1_q[i] | {6'h00, go_q[0], 1'b0};
      if (hit_ctl2[i]) rd_d = ctl2_q[i];
      if (hit_sec[i])  rd_d = sec_q[i];
      if (hit_cap[i])  rd_d = cap_q[i];
      if (hit_r0l[i])  rd_d = res0_q[i][7:0];
      if (hit_r0h[i])  rd_d = {6'h00, res0_q[i][9:8]};
      if (hit_r1l[i])  rd_d = res1_q[i][7:0];
      if (hit_r1h[i])  rd_d = {6'h00, res1_q[i][9:8]};
      if (hit_st[i])   rd_d = {3'h0, scnd[i], conv[i], acq[i], pre[i], flag_q[i]};
    end
  end

  // pin and switch controls, all registered
  wire [1:0] on_w = {ctl0_q[1][CTL0_ON], ctl0_q[0][CTL0_ON]};
  wire [NCH-1:0] sec_on1 = on_w[0] ? sec_q[0][NCH-1:0] : '0;
  wire [NCH-1:0] sec_on2 = on_w[1] ? sec_q[1][NCH-1:0] : '0;
  // level inverts on the second pass of a double sample
  wire [1:0] pol = {ctl2_q[1][CTL2_PRE_POL] ^ scnd[1], ctl2_q[0][CTL2_PRE_POL] ^ scnd[0]};
  // extra capacitor only hangs on the bus before conversion
  wire [1:0] cap_ok = (pre | acq) & on_w;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata               <= 8'h00;
      conv_done_flag          <= 2'b00;
      primary_channel_select1 <= 5'h00;
      primary_channel_select2 <= 5'h00;
      primary_connect         <= 2'b00;
      secondary_connect1      <= '0;
      secondary_connect2      <= '0;
      secondary_force_input1  <= '0;
      secondary_force_input2  <= '0;
      secondary_drive_en1     <= '0;
      secondary_drive_en2     <= '0;
      precharge_level         <= 2'b00;
      extra_cap_select1       <= 4'h0;
      extra_cap_select2       <= 4'h0;
    end else begin
      if (reg_rd) reg_rdata <= rd_d;
      conv_done_flag          <= flag_q;
      primary_channel_select1 <= ctl0_q[0][CTL0_CH_LSB +: 5];
      primary_channel_select2 <= ctl0_q[1][CTL0_CH_LSB +: 5];
      // primary switch opens during pre-charge
      primary_connect         <= on_w & ~pre;
      secondary_connect1      <= pre[0] ? '0 : sec_on1;
      secondary_connect2      <= pre[1] ? '0 : sec_on2;
      // direction override only; analog select is never touched here
      secondary_force_input1  <= sec_on1;
      secondary_force_input2  <= sec_on2;
      secondary_drive_en1     <= pre[0] ? sec_on1 : '0;
      secondary_drive_en2     <= pre[1] ? sec_on2 : '0;
      precharge_level         <= pol;
      extra_cap_select1       <= cap_ok[0] ? cap_q[0][3:0] : 4'h0;
      extra_cap_select2       <= cap_ok[1] ? cap_q[1][3:0] : 4'h0;
    end
  end
endmodule
`default_nettype wire

// *** tb/ccc_top_chk.sv ***
// Purpose: port-level checks of the cap-divider control block
// Assumes: pin outputs lag internal state by one cycle
// Notes:   stage lengths are the fixed 8/8/12 figures
`timescale 1ns/1ps
`default_nettype none
module ccc_top_chk import ccc_pkg::*; (
  input wire logic           mclk,
  input wire logic           rst_n,
  input wire logic [3:0]     reg_bank,
  input wire logic [7:0]     reg_addr,
  input wire logic           reg_wr,
  input wire logic [7:0]     reg_wdata,
  input wire logic           flag_clear1,
  input wire logic [1:0]     conv_done_flag,
  input wire logic [4:0]     primary_channel_select1,
  input wire logic [1:0]     primary_connect,
  input wire logic [NCH-1:0] secondary_connect1,
  input wire logic [NCH-1:0] secondary_force_input1,
  input wire logic [NCH-1:0] secondary_drive_en1,
  input wire logic [3:0]     extra_cap_select1,
  input wire logic [3:0]     extra_cap_select2
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  wire ctl0_wr = reg_wr && ((reg_bank == BANK_STD && reg_addr == OFS_CTL0) ||
                 (reg_bank == BANK_CVD1 && reg_addr == OFS_X_CTL0));
  wire drv1 = |secondary_drive_en1;
  wire cap1 = |extra_cap_select1;
  wire cap2 = |extra_cap_select2;
  sequence s_drv8; drv1 [*8]; endsequence
  sequence s_cap1_8; cap1 [*8]; endsequence
  sequence s_cap2_8; cap2 [*8]; endsequence
  sequence s_acq1; primary_connect[0] && secondary_connect1 == $past(secondary_drive_en1); endsequence
  property p_sel1; ctl0_wr |-> ##2 primary_channel_select1 == $past(reg_wdata[6:2], 2); endproperty
  property p_force1; ((secondary_connect1 | secondary_drive_en1) & ~secondary_force_input1) == '0; endproperty
  property p_drv1; drv1 |-> !primary_connect[0] && secondary_connect1 == '0; endproperty
  property p_pre_len1; $rose(drv1) |-> s_drv8 ##1 !drv1; endproperty
  property p_pre_acq1; $fell(drv1) && (|secondary_force_input1) |-> s_acq1; endproperty
  property p_cap1; $rose(cap1) |-> s_cap1_8 ##1 s_cap1_8 ##1 !cap1; endproperty
  property p_cap2; $rose(cap2) |-> s_cap2_8 ##1 s_cap2_8 ##1 !cap2; endproperty
  property p_flag_conv1; $rose(conv_done_flag[0]) |-> !cap1 && $past(extra_cap_select1, 8) == 4'h0; endproperty
  // the pin flag lags the clear by two cycles
  property p_flag_hold1; conv_done_flag[0] && !flag_clear1 && !$past(flag_clear1) |=> conv_done_flag[0]; endproperty
  a_sel1: assert property (p_sel1) else $error("primary select wrong");
  a_force1: assert property (p_force1) else $error("secondary not forced to input");
  a_drv1: assert property (p_drv1) else $error("pre-charge drive while connected");
  a_pre_len1: assert property (p_pre_len1) else $error("pre-charge drive length wrong");
  a_pre_acq1: assert property (p_pre_acq1) else $error("acquisition did not connect");
  a_cap1: assert property (p_cap1) else $error("extra cap window wrong");
  a_cap2: assert property (p_cap2) else $error("second extra cap window wrong");
  a_flag_conv1: assert property (p_flag_conv1) else $error("extra cap during conversion");
  a_flag_hold1: assert property (p_flag_hold1) else $error("done flag dropped");
endmodule
bind ccc_top ccc_top_chk u_chk (
  .mclk(mclk), .rst_n(rst_n), .reg_bank(reg_bank), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .flag_clear1(flag_clear1), .conv_done_flag(conv_done_flag),
  .primary_channel_select1(primary_channel_select1), .primary_connect(primary_connect),
  .secondary_connect1(secondary_connect1), .secondary_force_input1(secondary_force_input1),
  .secondary_drive_en1(secondary_drive_en1), .extra_cap_select1(extra_cap_select1),
  .extra_cap_select2(extra_cap_select2)
);
`default_nettype wire

// *** tb/ccc_sensor_model.sv ***
// Purpose: behavioural sensor electrodes behind both converters
// Assumes: the settled word depends only on the pre-charge level
// Notes:   a disconnected channel floats, so it shows a changing word
`timescale 1ns/1ps
`default_nettype none
module ccc_sensor_model import ccc_pkg::*; #(
  parameter logic [9:0] RES_HI = 10'h000,
  parameter logic [9:0] RES_LO = 10'h000
) (
  input  wire logic       mclk,
  input  wire logic [1:0] primary_connect,
  input  wire logic [1:0] precharge_level,
  output logic      [9:0] conv1_result,
  output logic      [9:0] conv2_result
);
  logic [9:0] churn_q = 10'h000;
  always_ff @(posedge mclk) churn_q <= churn_q + 10'h0CB;
  // charge sharing ends at the level the electrode was driven to
  assign conv1_result = primary_connect[0] ? (precharge_level[0] ? RES_HI : RES_LO) : churn_q;
  assign conv2_result = primary_connect[1] ? (precharge_level[1] ? RES_HI : RES_LO) : ~churn_q;
endmodule
`default_nettype wire

// *** tb/ccc_top_test.sv ***
// Purpose: self-checking bench for the cap-divider control block
// Assumes: sensor model word set by pre-charge level
// Notes:   register rows first, then conversion, refusal and reset cases
`timescale 1ns/1ps
`default_nettype none
module ccc_top_test import ccc_pkg::*;;
  localparam logic [9:0] RES_HI = 10'h2A5;
  localparam logic [9:0] RES_LO = 10'h15A;
  typedef struct packed {
    logic [3:0] wb;
    logic [7:0] wa;
    logic [7:0] wd;
    logic [3:0] rb;
    logic [7:0] ra;
    logic [7:0] ex;
  } ccc_row_t;
  localparam ccc_row_t ROWS [9] = '{
    '{BANK_STD, OFS_CTL0, 8'h7C, BANK_CVD1, OFS_X_CTL0, 8'h7C},
    '{BANK_CVD1, OFS_X_CTL0, 8'h28, BANK_STD, OFS_CTL0, 8'h28},
    '{BANK_STD, OFS_CTL2, 8'h06, BANK_CVD1, OFS_X_CTL2, 8'h06},
    '{BANK_CVD2, OFS_X_CTL0, 8'h50, BANK_CVD2, OFS_X_CTL0, 8'h50},
    '{BANK_CVD1, OFS_X_SEC, 8'hFF, BANK_CVD1, OFS_X_SEC, 8'h7F},
    '{BANK_CVD2, OFS_X_CAP, 8'hFF, BANK_CVD2, OFS_X_CAP, 8'h0F},
    '{BANK_CVD1, OFS_X_CAP, 8'h03, BANK_CVD2, OFS_X_CAP, 8'h0F},
    '{BANK_CVD2, OFS_CTL0, 8'h55, BANK_CVD2, OFS_CTL0, 8'h00},
    '{4'h3, OFS_CTL0, 8'h55, BANK_STD, OFS_CTL0, 8'h28}
  };
  logic           mclk = 1'h0;
  logic           rst_n = 1'h0;
  logic [3:0]     reg_bank = 4'h0;
  logic [7:0]     reg_addr = 8'h00;
  logic [7:0]     reg_wdata = 8'h00;
  logic [7:0]     rd_v;
  logic           reg_wr = 1'h0;
  logic           reg_rd = 1'h0;
  logic           flag_clear1 = 1'h0;
  logic           flag_clear2 = 1'h0;
  logic [1:0]     special_trigger = 2'h0;
  logic [9:0]     conv1_result, conv2_result;
  logic [7:0]     reg_rdata;
  logic [1:0]     conv_done_flag, primary_connect, precharge_level;
  logic [4:0]     primary_channel_select1, primary_channel_select2;
  logic [NCH-1:0] secondary_connect1, secondary_connect2, secondary_force_input1;
  logic [NCH-1:0] secondary_force_input2, secondary_drive_en1, secondary_drive_en2;
  logic [3:0]     extra_cap_select1, extra_cap_select2;
  int             error_cnt = 0;
  int             total_checks = 0;
  ccc_top DUT (
    .mclk(mclk), .rst_n(rst_n), .reg_bank(reg_bank), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .special_trigger(special_trigger),
    .conv1_result(conv1_result), .conv2_result(conv2_result), .flag_clear1(flag_clear1),
    .flag_clear2(flag_clear2), .conv_done_flag(conv_done_flag), .primary_connect(primary_connect),
    .primary_channel_select1(primary_channel_select1), .primary_channel_select2(primary_channel_select2),
    .secondary_connect1(secondary_connect1), .secondary_connect2(secondary_connect2),
    .secondary_force_input1(secondary_force_input1), .secondary_force_input2(secondary_force_input2),
    .secondary_drive_en1(secondary_drive_en1), .secondary_drive_en2(secondary_drive_en2),
    .precharge_level(precharge_level), .extra_cap_select1(extra_cap_select1),
    .extra_cap_select2(extra_cap_select2)
  );
  ccc_sensor_model #(.RES_HI(RES_HI), .RES_LO(RES_LO)) u_sensor (
    .mclk(mclk), .primary_connect(primary_connect), .precharge_level(precharge_level),
    .conv1_result(conv1_result), .conv2_result(conv2_result)
  );
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] b, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_bank <= b;
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge mclk);
    reg_wr <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [3:0] b, input logic [7:0] a);
    @(posedge mclk);
    reg_bank <= b;
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge mclk);
    reg_rd <= 1'h0;
    #1 rd_v = reg_rdata;
  endtask
  task automatic chkrd(input logic [3:0] b, input logic [7:0] a, input logic [7:0] ex);
    rd(b, a);
    chk(rd_v, ex);
  endtask
  task automatic pulse(input logic [1:0] trig, input logic [1:0] clr);
    @(posedge mclk);
    special_trigger <= trig;
    flag_clear1 <= clr[0];
    flag_clear2 <= clr[1];
    @(posedge mclk);
    special_trigger <= 2'h0;
    flag_clear1 <= 1'h0;
    flag_clear2 <= 1'h0;
  endtask
  task automatic wait_flag(input int n);
    for (int i = 0; i < 300 && conv_done_flag[n] !== 1'h1; i++) begin
      @(posedge mclk);
      #1;
    end
    chk(conv_done_flag[n], 1'h1);
  endtask
  task automatic print_verdict;
    $display("checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #1_000_000;
    error_cnt++;
    $display("Error at %0t ns: watchdog expired", $time);
    print_verdict;
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'h1;
    chkrd(BANK_CVD1, OFS_X_CTL2, REG_RESET);
    foreach (ROWS[k]) begin
      wr(ROWS[k].wb, ROWS[k].wa, ROWS[k].wd);
      chkrd(ROWS[k].rb, ROWS[k].ra, ROWS[k].ex);
    end
    $display("test register map done");
    wr(BANK_STD, OFS_CTL2, 8'h00);
    wr(BANK_CVD1, OFS_X_SEC, 8'h05);
    wr(BANK_CVD1, OFS_X_CAP, 8'h09);
    wr(BANK_STD, OFS_CTL0, 8'h29);
    #1;
    chk({secondary_connect1, secondary_force_input1, primary_connect[0]}, {7'h05, 7'h05, 1'h1});
    chk({extra_cap_select1, primary_channel_select1}, {4'h0, 5'h0A});
    wr(BANK_STD, OFS_CTL0, 8'h2B);
    repeat (3) @(posedge mclk);
    #1;
    chk({secondary_drive_en1, secondary_connect1, extra_cap_select1, precharge_level[0]},
        {7'h05, 7'h00, 4'h9, 1'h0});
    rd_v = 8'hFF;
    for (int i = 0; i < 40 && rd_v[CTL0_GO] !== 1'h0; i++) rd(BANK_CVD1, OFS_X_CTL0);
    repeat (2) @(posedge mclk);
    #1;
    chk({rd_v, conv_done_flag[0]}, {8'h29, 1'h1});
    chkrd(BANK_CVD1, OFS_X_RES0_LO, RES_LO[7:0]);
    chkrd(BANK_STD, OFS_RES_HI, {6'h00, RES_LO[9:8]});
    pulse(2'h0, 2'h1);
    @(posedge mclk);
    #1;
    chk(conv_done_flag[0], 1'h0);
    $display("test single conversion done");
    wr(BANK_CVD2, OFS_X_CTL2, 8'h07);
    wr(BANK_CVD2, OFS_X_SEC, 8'h12);
    wr(BANK_CVD2, OFS_X_CTL0, 8'h51);
    #1;
    chk({primary_channel_select2, secondary_connect2, secondary_force_input2}, {5'h14, 7'h12, 7'h12});
    pulse(2'h2, 2'h0);
    @(posedge mclk);
    #1;
    chk({secondary_drive_en2, secondary_connect2, extra_cap_select2, precharge_level[1]},
        {7'h12, 7'h00, 4'hF, 1'h1});
    wait_flag(1);
    chkrd(BANK_CVD2, OFS_X_RES0_LO, RES_HI[7:0]);
    chkrd(BANK_CVD2, OFS_X_RES0_HI, {6'h00, RES_HI[9:8]});
    chkrd(BANK_CVD2, OFS_X_RES1_LO, RES_LO[7:0]);
    pulse(2'h0, 2'h2);
    wr(BANK_STD, OFS_CTL1, 8'h02);
    wait_flag(0);
    wait_flag(1);
    pulse(2'h0, 2'h3);
    $display("test double and shared start done");
    wr(BANK_CVD2, OFS_X_CTL0, 8'h52);
    wr(BANK_STD, OFS_CTL0, 8'h2B);
    repeat (20) @(posedge mclk);
    wr(BANK_STD, OFS_CTL0, 8'h29);
    pulse(2'h1, 2'h0);
    repeat (40) @(posedge mclk);
    chkrd(BANK_CVD2, OFS_X_CTL0, 8'h50);
    chkrd(BANK_STD, OFS_CTL0, 8'h29);
    chk(conv_done_flag, 2'h0);
    $display("test abort and refusal done");
    @(posedge mclk);
    rst_n <= 1'h0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'h1;
    #1;
    chk({secondary_force_input1, primary_connect, extra_cap_select1}, 13'h0000);
    chkrd(BANK_CVD1, OFS_X_SEC, REG_RESET);
    chkrd(BANK_CVD2, OFS_X_CAP, REG_RESET);
    $display("test reset done");
    print_verdict;
  end
endmodule
`default_nettype wire
